/* File: logic/vsw_pkg.sv */
// Constants and types for the slave address window and remap block
package vsw_pkg;
	localparam int ADDR_W = 32;
	localparam int IO_ADDR_W = 4;
	localparam int IO_DATA_W = 16;
	localparam int WIN_W = 9;
	localparam int MASK_W = 16;
	localparam int PASS_LSB = 16;
	localparam int REMAP_MSB = 24;
	localparam int ZERO_LSB = 25;
	localparam int CMP_LSB = 16;
	localparam int AM_W = 6;
	localparam int A24_TOP = 23;
	localparam int A32_FIXED_LSB = 24;
	localparam int SRC_W = 2;
	// I/O register offsets (byte addresses, 16-bit words)
	localparam logic [IO_ADDR_W-1:0] OFF_WIN_SIZE = 4'h0;
	localparam logic [IO_ADDR_W-1:0] OFF_REMAP = 4'h2;
	localparam logic [IO_ADDR_W-1:0] OFF_CMP = 4'h4;
	localparam logic [IO_ADDR_W-1:0] OFF_MASK = 4'h6;
	localparam logic [IO_ADDR_W-1:0] OFF_CTRL = 4'h8;
	localparam logic [IO_ADDR_W-1:0] OFF_AMSRC = 4'hA;
	localparam logic [WIN_W-1:0] WIN_BYPASS = 9'h1FF;
	localparam logic [WIN_W-1:0] WIN_RST = 9'h1FF;
	localparam logic [WIN_W-1:0] REMAP_RST = 9'h000;
	localparam logic [MASK_W-1:0] MASK_RST = 16'h0000;
	localparam logic [MASK_W-1:0] CMP_RST = 16'h0000;
	localparam logic [AM_W-1:0] AMSRC_RST = 6'h00;
	// Control register bits
	localparam int CTL_A32_EN = 0;
	localparam int CTL_A24_EN = 1;
	localparam int CTL_SEL0_LSB = 2;
	localparam int CTL_SEL1_LSB = 4;
	localparam int CTL_W = 6;
	localparam logic [CTL_W-1:0] CTRL_RST = 6'h00;
	// Slave select address modifier sources
	typedef enum logic [SRC_W-1:0] {
		VSW_AM_STD = 2'h0,
		VSW_AM_USER = 2'h1,
		VSW_AM_ANY = 2'h2,
		VSW_AM_OFF = 2'h3
	} vsw_am_src_e;
	localparam logic [AM_W-1:0] AM_A32_STD = 6'h09;
	localparam logic [AM_W-1:0] AM_A24_STD = 6'h39;
	// Local regions
	localparam logic [ADDR_W-1:0] NA_LO = 32'h000E0000;
	localparam logic [ADDR_W-1:0] NA_HI = 32'h000EFFFF;
	localparam logic [ADDR_W-1:0] EXT_LO = 32'h00100000;
	localparam logic [ADDR_W-1:0] EXT_HI = 32'h00FFFFFF;
endpackage : vsw_pkg

/* File: logic/vsw_slave_window.sv */
// Slave address decode, window sizing and remap into local address space
`timescale 1ns/1ps
`default_nettype none
module vsw_slave_window #(
	parameter int DUMMY_W = 1
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic io_sel_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	input wire logic io_word_in,
	input wire logic [vsw_pkg::IO_ADDR_W-1:0] io_addr_in,
	input wire logic [vsw_pkg::IO_DATA_W-1:0] io_wdata_in,
	output logic [vsw_pkg::IO_DATA_W-1:0] io_rdata_out,
	output logic io_ack_out,
	input wire logic vme_as_in,
	input wire logic vme_a32_in,
	input wire logic [vsw_pkg::AM_W-1:0] vme_am_in,
	input wire logic [vsw_pkg::ADDR_W-1:0] vme_addr_in,
	input wire logic master_blt_in,
	input wire logic [vsw_pkg::ADDR_W-1:0] master_laddr_in,
	output logic [vsw_pkg::ADDR_W-1:0] local_addr_out,
	output logic slave_hit_out,
	output logic dtack_out
);
	import vsw_pkg::*;

	logic [WIN_W-1:0] slave_window_size;
	logic [WIN_W-1:0] slave_remap_base;
	logic [MASK_W-1:0] slave_decode_mask;
	logic [MASK_W-1:0] slave_compare;
	logic [CTL_W-1:0] slave_ctrl;
	logic [AM_W-1:0] slave_am_source;
	logic [1:0] as_sync;
	logic [ADDR_W-1:0] addr_s1;
	logic [ADDR_W-1:0] addr_s2;
	logic [AM_W-1:0] am_s1;
	logic [AM_W-1:0] am_s2;
	logic a32_s1;
	logic a32_s2;

	// Bus writes need a full 16-bit access; byte accesses are ignored
	wire io_access = io_sel_in && io_word_in && (io_wr_in || io_rd_in);
	wire io_write = io_sel_in && io_word_in && io_wr_in;
	wire wr_size = io_write && (io_addr_in == OFF_WIN_SIZE);
	wire wr_remap = io_write && (io_addr_in == OFF_REMAP);
	wire wr_cmp = io_write && (io_addr_in == OFF_CMP);
	wire any_cmp = io_access && (io_addr_in == OFF_CMP);
	wire wr_mask = io_write && (io_addr_in == OFF_MASK);
	wire wr_ctrl = io_write && (io_addr_in == OFF_CTRL);
	wire wr_amsrc = io_write && (io_addr_in == OFF_AMSRC);

	// Upper seven bits of size and remap read as zero; software need not mask them
	wire [IO_DATA_W-1:0] rd_mux =
		(io_addr_in == OFF_WIN_SIZE) ? {7'h00, slave_window_size} :
		(io_addr_in == OFF_REMAP) ? {7'h00, slave_remap_base} :
		(io_addr_in == OFF_CMP) ? slave_compare :
		(io_addr_in == OFF_MASK) ? slave_decode_mask :
		(io_addr_in == OFF_CTRL) ? {10'h000, slave_ctrl} :
		(io_addr_in == OFF_AMSRC) ? {10'h000, slave_am_source} : 16'h0000;

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			slave_window_size <= WIN_RST;
			slave_remap_base <= REMAP_RST;
			slave_compare <= CMP_RST;
			slave_decode_mask <= MASK_RST;
			slave_ctrl <= CTRL_RST;
			slave_am_source <= AMSRC_RST;
			io_rdata_out <= 16'h0000;
			io_ack_out <= 1'b0;
		end else begin
			if (wr_size) slave_window_size <= io_wdata_in[WIN_W-1:0];
			if (wr_remap) slave_remap_base <= io_wdata_in[WIN_W-1:0];
			if (wr_cmp) slave_compare <= io_wdata_in;
			// Any compare access wipes the mask, so mask goes second
			if (any_cmp) slave_decode_mask <= MASK_RST;
			else if (wr_mask) slave_decode_mask <= io_wdata_in;
			if (wr_ctrl) slave_ctrl <= io_wdata_in[CTL_W-1:0];
			if (wr_amsrc) slave_am_source <= io_wdata_in[AM_W-1:0];
			io_rdata_out <= (io_sel_in && io_rd_in && io_word_in) ? rd_mux : 16'h0000;
			io_ack_out <= io_access;
		end
	end

	// Two-stage synchronisers for the bus side; address is stable under AS
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			as_sync <= 2'h0;
			addr_s1 <= 32'h00000000;
			addr_s2 <= 32'h00000000;
			am_s1 <= 6'h00;
			am_s2 <= 6'h00;
			a32_s1 <= 1'b0;
			a32_s2 <= 1'b0;
		end else begin
			as_sync <= {as_sync[0], vme_as_in};
			addr_s1 <= vme_addr_in;
			addr_s2 <= addr_s1;
			am_s1 <= vme_am_in;
			am_s2 <= am_s1;
			a32_s1 <= vme_a32_in;
			a32_s2 <= a32_s1;
		end
	end

	wire as_s = as_sync[1];

	// Address modifier acceptance per slave select
	wire [SRC_W-1:0] sel0 = slave_ctrl[CTL_SEL0_LSB +: SRC_W];
	wire [SRC_W-1:0] sel1 = slave_ctrl[CTL_SEL1_LSB +: SRC_W];
	wire am_ok0 = (sel0 == VSW_AM_ANY) ||
		(sel0 == VSW_AM_STD && am_s2 == AM_A32_STD) ||
		(sel0 == VSW_AM_USER && am_s2 == slave_am_source);
	wire am_ok1 = (sel1 == VSW_AM_ANY) ||
		(sel1 == VSW_AM_STD && am_s2 == AM_A24_STD) ||
		(sel1 == VSW_AM_USER && am_s2 == slave_am_source);

	// Mask set bits become don't-cares; A32 always ignores A23-A16
	wire [MASK_W-1:0] a32_care = ~slave_decode_mask & 16'hFF00;
	wire [MASK_W-1:0] cmp_diff = addr_s2[ADDR_W-1:CMP_LSB] ^ slave_compare;
	wire hit_a32 = slave_ctrl[CTL_A32_EN] && a32_s2 && am_ok0 &&
		((cmp_diff & a32_care) == 16'h0000);
	// A24 space: compare bits 7..0 match A23-A16
	wire [7:0] a24_care = ~slave_decode_mask[7:0];
	wire hit_a24 = slave_ctrl[CTL_A24_EN] && !a32_s2 && am_ok1 &&
		(((addr_s2[A24_TOP:CMP_LSB] ^ slave_compare[7:0]) & a24_care) == 8'h00);
	wire hit = as_s && (hit_a32 || hit_a24);

	// Remap: size bit 1 passes the bus bit, 0 substitutes remap bit
	wire bypass = (slave_window_size == WIN_BYPASS);
	wire [WIN_W-1:0] bus_mid = addr_s2[REMAP_MSB:PASS_LSB];
	wire [WIN_W-1:0] remap_mid = (bus_mid & slave_window_size) |
		(slave_remap_base & ~slave_window_size);
	wire [WIN_W-1:0] mid = bypass ? bus_mid : remap_mid;
	// Slave block transfers arrive as ordinary start addresses, so they remap too
	wire [ADDR_W-1:0] slave_laddr = {7'h00, mid, addr_s2[PASS_LSB-1:0]};
	// Local master block transfers carry a local address: no remap
	wire [ADDR_W-1:0] next_local_addr = master_blt_in ? master_laddr_in : slave_laddr;

	wire in_na = (slave_laddr >= NA_LO) && (slave_laddr <= NA_HI);
	wire in_ext = (slave_laddr >= EXT_LO) && (slave_laddr <= EXT_HI);
	// Extended range acks with no check for fitted memory; data may be junk
	wire next_dtack = hit && !master_blt_in && (in_ext || !in_na);

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			local_addr_out <= 32'h00000000;
			slave_hit_out <= 1'b0;
			dtack_out <= 1'b0;
		end else begin
			local_addr_out <= next_local_addr;
			slave_hit_out <= hit && !master_blt_in;
			dtack_out <= next_dtack;
		end
	end
endmodule : vsw_slave_window
`default_nettype wire

/* File: bench/vsw_slave_window_sva.sv */
// Port assertions for the slave window block
`timescale 1ns/1ps
`default_nettype none
module vsw_slave_window_sva (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic io_sel_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	input wire logic io_word_in,
	input wire logic [vsw_pkg::IO_ADDR_W-1:0] io_addr_in,
	input wire logic [vsw_pkg::IO_DATA_W-1:0] io_rdata_out,
	input wire logic io_ack_out,
	input wire logic [vsw_pkg::ADDR_W-1:0] vme_addr_in,
	input wire logic master_blt_in,
	input wire logic [vsw_pkg::ADDR_W-1:0] master_laddr_in,
	input wire logic [vsw_pkg::ADDR_W-1:0] local_addr_out,
	input wire logic slave_hit_out,
	input wire logic dtack_out
);
	import vsw_pkg::*;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	wire req = io_sel_in && io_word_in && (io_wr_in || io_rd_in);
	wire na_hit = local_addr_out >= NA_LO && local_addr_out <= NA_HI;
	wire ext_hit = local_addr_out >= EXT_LO && local_addr_out <= EXT_HI;
	sequence s_req; req; endsequence
	// Five quiet cycles cover the two sync stages plus the output register
	sequence s_calm; (!master_blt_in && $stable(vme_addr_in)) [*5]; endsequence
	AST_IO_ACK: assert property (s_req |=> io_ack_out) else $error("no io ack");
	AST_IO_NOACK: assert property (!req |=> !io_ack_out) else $error("stray io ack");
	AST_RD_UPPER: assert property (s_req ##0 (io_rd_in && io_addr_in < 4'h4)
		|=> io_rdata_out[15:9] == 7'h00) else $error("upper bits set");
	AST_TOP_ZERO: assert property (slave_hit_out |-> local_addr_out[31:25] == 7'h00)
		else $error("top address bits set");
	AST_NA_NOACK: assert property (slave_hit_out && na_hit |-> !dtack_out)
		else $error("dtack in closed region");
	AST_EXT_ACK: assert property (slave_hit_out && ext_hit |-> dtack_out)
		else $error("no dtack in extended range");
	AST_LOW_PASS: assert property (s_calm |-> local_addr_out[15:0] == vme_addr_in[15:0])
		else $error("low address altered");
	AST_BLT_PASS: assert property (master_blt_in [*2] |-> local_addr_out == $past(master_laddr_in))
		else $error("block transfer address remapped");
	AST_BLT_NOHIT: assert property (master_blt_in [*4] |-> !slave_hit_out)
		else $error("hit during block transfer");
endmodule : vsw_slave_window_sva
`default_nettype wire

/* File: bench/vsw_vme_master.sv */
// Remote bus master model that opens and closes slave cycles
`timescale 1ns/1ps
`default_nettype none
module vsw_vme_master (
	input wire logic core_clk_in,
	output logic vme_as_out,
	output logic vme_a32_out,
	output logic [vsw_pkg::AM_W-1:0] vme_am_out,
	output logic [vsw_pkg::ADDR_W-1:0] vme_addr_out
);
	import vsw_pkg::*;
	initial {vme_as_out, vme_a32_out, vme_am_out, vme_addr_out} = '0;
	// A block start address is just one such cycle, held for the whole strobe
	task automatic start(input logic w32, input logic [AM_W-1:0] m, input logic [ADDR_W-1:0] a);
		@(posedge core_clk_in);
		{vme_a32_out, vme_am_out, vme_addr_out} <= {w32, m, a};
		vme_as_out <= 1'b1;
	endtask : start
	// Released address and modifier lines show the inverse, so a stale address cannot pass for a live one
	task automatic stop;
		@(posedge core_clk_in);
		vme_as_out <= 1'b0;
		{vme_am_out, vme_addr_out} <= ~{vme_am_out, vme_addr_out};
	endtask : stop
endmodule : vsw_vme_master
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the slave window block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	import vsw_pkg::*;
	logic clk = 0, rst = 1, sel = 0, wr = 0, rd = 0, word = 0, blt = 0, as, a32, hit, dt, ack;
	logic [3:0] ia = 0;
	logic [15:0] wd = 0, rdat, q;
	logic [15:0] mv[3] = '{16'h0000, 16'h0001, 16'h00FF};
	logic [31:0] av[3] = '{32'h0011_0000, 32'h0011_0000, 32'h00AB_0000};
	logic [5:0] am;
	logic [31:0] va, la, e, ml = 0;
	logic [8:0] sz = 9'h1FF, rm = 9'h1FF;
	int mismatches = 0, checked = 0, cyc = 0, seed = 32'h7ef0df8e, i, k;
	vsw_slave_window vsw_slave_window_i(.core_clk_in(clk), .sys_rst_in(rst), .io_sel_in(sel),
		.io_wr_in(wr), .io_rd_in(rd), .io_word_in(word), .io_addr_in(ia), .io_wdata_in(wd),
		.io_rdata_out(rdat), .io_ack_out(ack), .vme_as_in(as), .vme_a32_in(a32), .vme_am_in(am),
		.vme_addr_in(va), .master_blt_in(blt), .master_laddr_in(ml), .local_addr_out(la),
		.slave_hit_out(hit), .dtack_out(dt));
	vsw_vme_master vsw_vme_master_i(.core_clk_in(clk), .vme_as_out(as), .vme_a32_out(a32),
		.vme_am_out(am), .vme_addr_out(va));
	initial forever #2 clk = ~clk;
	always @(posedge clk) if (++cyc > 5000) begin
		mismatches++;
		end_sim;
	end
	task automatic end_sim;
		$display("counts: checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic io(input logic w, input logic bw, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		{sel, word, wr, rd, ia, wd} <= {1'b1, bw, w, !w, a, d};
		@(posedge clk);
		{sel, wr, rd} <= 3'h0;
		#1 q = rdat;
		`CHK(ack, bw)
	endtask : io
	function automatic logic [31:0] exp_la(input logic [8:0] s, r, input logic [31:0] a);
		return {7'h00, (a[24:16] & s) | (r & ~s), a[15:0]};
	endfunction : exp_la
	task automatic setwin(input logic [8:0] s, r);
		{sz, rm} = {s, r};
		io(1, 1, OFF_WIN_SIZE, {7'h00, s});
		io(1, 1, OFF_REMAP, {7'h00, r});
	endtask : setwin
	// Hold time varies so the window sees prompt and slow masters alike
	task automatic acc(input logic w32, input logic [5:0] m, input logic [31:0] a, input logic h);
		vsw_vme_master_i.start(w32, m, a);
		repeat (4 + ($random(seed) & 3)) @(posedge clk);
		#1 e = exp_la(sz, rm, a);
		`CHK(hit, h)
		`CHK(la, e)
		`CHK(dt, h && !(e >= NA_LO && e <= NA_HI))
		vsw_vme_master_i.stop;
		repeat (4) @(posedge clk);
	endtask : acc
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (k = 0; k < 8; k++) begin
			io(0, 1, 4'(2 * k), 16'h0000);
			`CHK(q, k ? 16'h0000 : {7'h00, WIN_RST})
		end
		io(1, 1, OFF_REMAP, 16'hFFFF);
		io(1, 0, OFF_REMAP, 16'h0000);
		io(0, 1, OFF_REMAP, 16'h0000);
		`CHK(q, 16'h01FF)
		io(1, 1, OFF_MASK, 16'h00FF);
		io(0, 1, OFF_CMP, 16'h0000);
		io(0, 1, OFF_MASK, 16'h0000);
		`CHK(q, 16'h0000)
		io(1, 1, OFF_CMP, 16'h1210);
		io(1, 1, OFF_AMSRC, 16'h003D);
		$display("test registers done");
		for (k = 0; k < 4; k++) begin
			io(1, 1, OFF_CTRL, {10'h000, 2'(k), 2'(k), 2'h3});
			acc(0, k == 1 ? 6'h3D : AM_A24_STD, 32'h0010_0000, k != 3);
			acc(1, k == 1 ? 6'h3D : AM_A32_STD, 32'h1210_0000, k != 3);
		end
		io(1, 1, OFF_CTRL, 16'h0023);
		for (k = 0; k < 3; k++) begin
			io(1, 1, OFF_MASK, mv[k]);
			acc(0, AM_A24_STD, av[k], k != 0);
		end
		acc(1, AM_A32_STD, 32'h12FF_FFFF, 1);
		acc(1, AM_A32_STD, 32'h1300_0000, 0);
		$display("test decode done");
		for (i = 0; i < 40; i++) begin
			k = ($random(seed) & 15) % 10;
			setwin(i ? 9'((1 << k) - 1) : 9'h000, i ? 9'($random(seed)) : 9'h00E);
			acc(i[0], i[0] ? AM_A32_STD : AM_A24_STD, {i[0] ? 8'h12 : 8'h00, 24'($random(seed))}, 1);
		end
		$display("test remap done");
		@(posedge clk);
		{blt, ml} <= {1'b1, 32'($random(seed))};
		vsw_vme_master_i.start(0, AM_A24_STD, 32'h0010_0000);
		repeat (4) @(posedge clk);
		#1 `CHK(la, ml)
		`CHK(hit, 1'b0)
		vsw_vme_master_i.stop;
		blt <= 1'b0;
		$display("test block transfer done");
		end_sim;
	end
endmodule : testbench
bind vsw_slave_window vsw_slave_window_sva vsw_slave_window_sva_i(.*);
`default_nettype wire
